// [rtl/tic_input_timing.sv]
/*
  Device control register and input timing front end of the TDM switch:
  host register access, mode decode, loopback selection and frame
  boundary detection on the sampled input clock and frame pulse.
  Assumes a synchronous host port on clk_sys and timing pins that are
  asynchronous to it.
*/
// How it works
// - Slave PLL enable low keeps the PLL off in slave mode.
// - Slave PLL enable and oscillator enable both high run the PLL in slave mode.
// - PLL running in slave: high output clocks and pulse lock to selected reference.
// - Two-bit operation mode field picks master or slave operation.
// - Loopback low: input clock and frame pulse come from the pins.
// - Loopback high in master: output clock two and pulse two feed the input.
// - Position field: zero pulse straddles boundary, one pulse starts at it.
// - Edge field picks falling (zero) or rising (one) input clock edge.
// - Polarity field sets the active level of the input frame pulse.
`timescale 1ns/1ns
`default_nettype none
`include "tic_cfg.svh"

module tic_input_timing (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire tic_pkg::tic_host_req_type hostReq,
  output var  logic [15:0]               hostRdata,
  input  wire logic                      oscillatorEnable,
  input  wire logic                      inputClock,
  input  wire logic                      inputFramePulse,
  input  wire logic                      outputClockTwo,
  input  wire logic                      outputFramePulseTwo,
  output var  tic_pkg::tic_timing_type   timing
);
  import tic_pkg::*;

  tic_state_type  st_reg;
  tic_state_type  st_next;
  logic           pinClk;
  logic           pinFp;
  logic           loopClk;
  logic           loopFp;

  tic_pin_sync uSyncClk (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (inputClock),
    .level   (pinClk)
  );

  tic_pin_sync uSyncFp (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (inputFramePulse),
    .level   (pinFp)
  );

  // Loopback sources run at 16.384 MHz against a 25 MHz sampler, so edges
  // seen in loopback alias; adequate for framing checks only
  tic_pin_sync uSyncLoopClk (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (outputClockTwo),
    .level   (loopClk)
  );

  tic_pin_sync uSyncLoopFp (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (outputFramePulseTwo),
    .level   (loopFp)
  );

  always_comb begin
    logic           hit;
    logic           isMaster;
    logic           pllOn;
    logic           loopOn;
    logic           selClk;
    logic           selFp;
    logic           fpActive;
    logic           edgeSeen;
    logic           boundary;
    logic           ctrlWrite;
    tic_opmode_type modeSel;
    tic_rate_type   rate;

    hit       = 1'b0;
    isMaster  = 1'b0;
    pllOn     = 1'b0;
    loopOn    = 1'b0;
    selClk    = 1'b0;
    selFp     = 1'b0;
    fpActive  = 1'b0;
    edgeSeen  = 1'b0;
    boundary  = 1'b0;
    ctrlWrite = 1'b0;
    modeSel   = TIC_MODE_MASTER;
    rate      = TIC_RATE_16M;
    st_next   = st_reg;

    // Host access: only the control register is mapped here
    if (hostReq.addr == `TIC_CTRL_ADDR) begin
      hit = hostReq.sel;
    end else begin
      hit = 1'b0;
    end
    if (hit && hostReq.wr) begin
      st_next.ctrl = hostReq.wdata & `TIC_CTRL_RSVD_MASK;
      ctrlWrite    = 1'b1;
    end
    if (hostReq.sel && hostReq.rd) begin
      st_next.rdata = hit ? (st_reg.ctrl & `TIC_CTRL_RSVD_MASK) : 16'h0000;
    end

    // Mode decode from the stored control word
    modeSel = tic_opmode_type'(st_reg.ctrl[`TIC_BIT_MODE_HI:`TIC_BIT_MODE_LO]);
    case (modeSel)
      TIC_MODE_MASTER: begin
        isMaster = 1'b1;
      end
      TIC_MODE_MASTER_ALT: begin
        isMaster = 1'b1;
      end
      default: begin
        isMaster = 1'b0;
      end
    endcase

    // PLL use matters only in slave operation
    pllOn = !isMaster && st_reg.ctrl[`TIC_BIT_PLL_EN] && oscillatorEnable;

    // Loopback is ignored in slave operation
    loopOn = isMaster && st_reg.ctrl[`TIC_BIT_LOOPBACK];
    if (loopOn) begin
      selClk = loopClk;
      selFp  = loopFp;
    end else begin
      selClk = pinClk;
      selFp  = pinFp;
    end

    // Normalise the pulse to active high
    fpActive = st_reg.ctrl[`TIC_BIT_FP_POL] ? selFp : !selFp;

    // Pick the input clock edge that marks the boundary
    if (st_reg.ctrl[`TIC_BIT_EDGE_SEL]) begin
      edgeSeen = selClk && !st_reg.clkPrev;
    end else begin
      edgeSeen = !selClk && st_reg.clkPrev;
    end
    st_next.clkPrev = selClk;

    // Straddling pulse: boundary at the edge inside it; starting pulse: at its first edge
    if (edgeSeen) begin
      if (st_reg.ctrl[`TIC_BIT_FP_POS]) begin
        boundary = fpActive && !st_reg.fpPrev;
      end else begin
        boundary = fpActive;
      end
      st_next.fpPrev = fpActive;
    end

    // Pulse width check, counted in selected clock edges
    st_next.timing.widthError = st_reg.timing.widthError && !ctrlWrite;
    if (edgeSeen) begin
      if (fpActive) begin
        if (st_reg.fpEdges != `TIC_FP_CNT_MAX) begin
          st_next.fpEdges = 3'(st_reg.fpEdges + 3'h1);
        end
      end else begin
        st_next.fpEdges = 3'h0;
        if (st_reg.fpPrev && (st_reg.fpEdges != `TIC_FP_EDGES)) begin
          st_next.timing.widthError = 1'b1;
        end
      end
    end

    // Rate select and the matching pulse width
    rate = tic_rate_type'(st_reg.ctrl[`TIC_BIT_RATE_HI:`TIC_BIT_RATE_LO]);
    st_next.timing.rateSelect   = rate;
    st_next.timing.rateReserved = 1'b0;
    case (rate)
      TIC_RATE_16M: begin
        st_next.timing.frameWidthNs = 8'(`TIC_FP_WIDTH_16M_NS);
      end
      TIC_RATE_8M: begin
        st_next.timing.frameWidthNs = 8'(`TIC_FP_WIDTH_8M_NS);
      end
      TIC_RATE_4M: begin
        st_next.timing.frameWidthNs = 8'(`TIC_FP_WIDTH_4M_NS);
      end
      default: begin
        st_next.timing.frameWidthNs = 8'h00;
        st_next.timing.rateReserved = 1'b1;
      end
    endcase

    st_next.timing.masterMode          = isMaster;
    st_next.timing.pllEnable           = pllOn;
    st_next.timing.lowOutputsFromInput = pllOn;
    st_next.timing.highOutputsFromRef  = pllOn;
    st_next.timing.loopbackActive      = loopOn;
    st_next.timing.frameBoundary       = boundary;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.ctrl <= `TIC_CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hostRdata = st_reg.rdata;
  assign timing    = st_reg.timing;

endmodule // tic_input_timing

`default_nettype wire

// [common/tic_cfg.svh]
/*
  Offsets, field positions, reset values and timing figures for the
  input timing control block. Assumes inclusion by bare name from the
  package and the design files.
*/
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

`define TIC_CTRL_ADDR        14'h0000
`define TIC_CTRL_RESET       16'h0000
`define TIC_CTRL_RSVD_MASK   16'h3FFF

`define TIC_BIT_PLL_EN       13
`define TIC_BIT_MODE_HI      12
`define TIC_BIT_MODE_LO      11
`define TIC_BIT_LOOPBACK     10
`define TIC_BIT_FP_POS       9
`define TIC_BIT_EDGE_SEL     8
`define TIC_BIT_FP_POL       7
`define TIC_BIT_RATE_HI      6
`define TIC_BIT_RATE_LO      5

`define TIC_CLK_PERIOD_NS    40
`define TIC_FP_WIDTH_16M_NS  61
`define TIC_FP_WIDTH_8M_NS   122
`define TIC_FP_WIDTH_4M_NS   244
`define TIC_FP_EDGES         3'h1
`define TIC_FP_CNT_MAX       3'h7

`endif

// [common/tic_pkg.sv]
/*
  Types shared by the input timing control block.
  Assumes the constants header is on the include path.
*/
`include "tic_cfg.svh"

package tic_pkg;

  typedef enum logic [1:0] {
    TIC_MODE_MASTER     = 2'b00,
    TIC_MODE_SLAVE      = 2'b01,
    TIC_MODE_MASTER_ALT = 2'b10,
    TIC_MODE_SLAVE_ALT  = 2'b11
  } tic_opmode_type;

  typedef enum logic [1:0] {
    TIC_RATE_16M = 2'b00,
    TIC_RATE_8M  = 2'b01,
    TIC_RATE_4M  = 2'b10,
    TIC_RATE_RSV = 2'b11
  } tic_rate_type;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } tic_host_req_type;

  typedef struct packed {
    logic         masterMode;
    logic         pllEnable;
    logic         lowOutputsFromInput;
    logic         highOutputsFromRef;
    logic         loopbackActive;
    logic         frameBoundary;
    logic         widthError;
    logic         rateReserved;
    tic_rate_type rateSelect;
    logic [7:0]   frameWidthNs;
  } tic_timing_type;

  typedef struct packed {
    logic [15:0]    ctrl;
    logic [15:0]    rdata;
    logic           clkPrev;
    logic           fpPrev;
    logic [2:0]     fpEdges;
    tic_timing_type timing;
  } tic_state_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } tic_sync_type;

endpackage

// [rtl/tic_pin_sync.sv]
/*
  Three-stage synchroniser for one level from outside the clk_sys domain.
  Assumes the input may change at any time relative to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module tic_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output var  logic level
);
  import tic_pkg::*;

  tic_sync_type st_reg;
  tic_sync_type st_next;

  // First stage feeds only the second; the level moves once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pinIn;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;

endmodule // tic_pin_sync

`default_nettype wire

// [sim/tic_input_timing_chk.sv]
/*
  Port checker for the input timing control block.
  Bound to tic_input_timing; sees its ports and nothing else.
*/
`timescale 1ns/1ns
`default_nettype none

module tic_input_timing_chk (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire tic_pkg::tic_host_req_type hostReq,
  input wire logic [15:0]               hostRdata,
  input wire logic                      oscillatorEnable,
  input wire tic_pkg::tic_timing_type   timing
);
  import tic_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Outputs hold reset values for one edge after release
  logic live_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      live_reg <= 1'b0;
    else
      live_reg <= 1'b1;
  end
  sequence s_wr; hostReq.sel && hostReq.wr && hostReq.addr == 14'h0000; endsequence
  sequence s_rd; hostReq.sel && hostReq.rd && !hostReq.wr && hostReq.addr == 14'h0000; endsequence
  property p_rdwr; s_wr ##1 s_rd |=> hostRdata == ($past(hostReq.wdata, 2) & 16'h3FFF); endproperty
  a_rdwr: assert property (p_rdwr) else $error("readback differs");
  property p_rsvd; hostRdata[15:14] == 2'b00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("top bits set");
  property p_pll; timing.pllEnable |-> !timing.masterMode; endproperty
  a_pll: assert property (p_pll) else $error("pll on in master");
  property p_osc; !$past(oscillatorEnable) |-> !timing.pllEnable; endproperty
  a_osc: assert property (p_osc) else $error("pll on without osc");
  property p_low; timing.lowOutputsFromInput == timing.pllEnable; endproperty
  a_low: assert property (p_low) else $error("low outputs source");
  property p_high; timing.highOutputsFromRef == timing.pllEnable; endproperty
  a_high: assert property (p_high) else $error("high outputs source");
  property p_lb; timing.loopbackActive |-> timing.masterMode; endproperty
  a_lb: assert property (p_lb) else $error("loopback in slave");
  property p_fb; timing.frameBoundary |=> !timing.frameBoundary; endproperty
  a_fb: assert property (p_fb) else $error("boundary too long");
  property p_width;
    live_reg |-> timing.frameWidthNs == (timing.rateSelect == 2'b00 ? 8'h3D :
      timing.rateSelect == 2'b01 ? 8'h7A : timing.rateSelect == 2'b10 ? 8'hF4 : 8'h00)
      && timing.rateReserved == (timing.rateSelect == 2'b11);
  endproperty
  a_width: assert property (p_width) else $error("rate decode");
  // Only a control write may drop the width flag
  property p_sticky;
    timing.widthError && !(hostReq.sel && hostReq.wr && hostReq.addr == 14'h0000)
      |=> timing.widthError;
  endproperty
  a_sticky: assert property (p_sticky) else $error("width flag lost");
endmodule // tic_input_timing_chk

bind tic_input_timing tic_input_timing_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .hostReq(hostReq), .hostRdata(hostRdata), .oscillatorEnable(oscillatorEnable),
  .timing(timing));

`default_nettype wire

// [sim/tic_tdm_src.sv]
/*
  TDM timing source: input clock and frame pulse of the backplane.
  Idle levels set at time zero, then driven only inside run(); the clock stands still between runs.
*/
`timescale 1ns/1ns
`default_nettype none

module tic_tdm_src (
  output var logic ck,
  output var logic fp
);
  initial begin
    ck = 1'b0;
    fp = 1'b1;
  end
  // Pulse moves on the off edge, so it is seen on exactly wide selected edges
  task automatic run(input int frames, input logic edgeSel, input logic actHigh, input int wide);
    fp = !actHigh;
    #640;
    ck = edgeSel;
    #640;
    for (int f = 0; f < frames * 8; f++) begin
      ck = !edgeSel;
      fp = ((f % 8) < wide) ? actHigh : !actHigh;
      #160;
      ck = edgeSel;
      #160;
    end
  endtask
endmodule // tic_tdm_src

`default_nettype wire

// [sim/tb_top.sv]
/*
  Self-checking bench for tic_input_timing against a behavioural model.
  Assumes a 25 MHz clk_sys and two timing sources: pins and loopback.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import tic_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  tic_host_req_type hostReq = '0;
  logic [15:0]      hostRdata;
  logic             osc = 1'b0;
  logic             pinCk, pinFp, loopCk, loopFp;
  tic_timing_type   timing;
  logic [15:0]      seenT;
  logic [31:0]      rng = 32'h0000_0049;
  int               nErrors = 0;
  int               compares = 0;
  int               nBound = 0;
  int               ctrlM = 0;

  always #20 clk_sys = !clk_sys;
  // Counted on the falling edge, where the one-cycle pulse has settled
  always @(negedge clk_sys) if (timing.frameBoundary === 1'b1) nBound++;
  assign seenT = {timing.masterMode, timing.pllEnable, timing.lowOutputsFromInput,
    timing.highOutputsFromRef, timing.loopbackActive, timing.rateReserved,
    timing.rateSelect, timing.frameWidthNs};

  tic_input_timing u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hostReq(hostReq),
    .hostRdata(hostRdata), .oscillatorEnable(osc), .inputClock(pinCk),
    .inputFramePulse(pinFp), .outputClockTwo(loopCk), .outputFramePulseTwo(loopFp),
    .timing(timing));
  tic_tdm_src u_src (.ck(pinCk), .fp(pinFp));
  tic_tdm_src u_lp (.ck(loopCk), .fp(loopFp));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] expT(input int c, input logic o);
    logic       m;
    logic [1:0] r;
    m = !c[11];
    r = c[6:5];
    return {m, !m & c[13] & o, !m & c[13] & o, !m & c[13] & o, m & c[10], r == 2'b11, r,
      r == 2'b00 ? 8'h3D : r == 2'b01 ? 8'h7A : r == 2'b10 ? 8'hF4 : 8'h00};
  endfunction
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic testDone();
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One whole request per falling edge; strobes last one cycle
  task automatic bus(input logic w, input logic r, input logic [13:0] a, input logic [15:0] d);
    hostReq = '{sel: w | r, wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_sys);
  endtask
  task automatic wrM(input int v);
    ctrlM = v;
    bus(1'b1, 1'b0, 14'h0000, v[15:0]);
  endtask
  task automatic rdChk(input logic [13:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, 14'h0000, 16'h0000);
    chk("rdata", hostRdata, exp);
  endtask

  initial begin
    #1000000;
    nErrors++;
    testDone();
  end
  initial begin
    int v;
    int n0;
    logic pins;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    rdChk(14'h0000, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      v = xs();
      osc = v[31] | (i < 4);
      if (i < 4)
        v = (i << 11) | (i << 5) | 32'h2400;
      v &= 32'h3FFF;
      wrM(v);
      rdChk(14'h0000, ctrlM[15:0]);
      chk("timing", seenT, expT(ctrlM, osc));
    end
    // Unmapped space takes no write and reads as zero
    bus(1'b1, 1'b0, 14'h0001, 16'hFFFF);
    rdChk(14'h0001, 16'h0000);
    rdChk(14'h0000, ctrlM[15:0]);
    for (int k = 0; k < 12; k++) begin
      v = (k < 8) ? (k << 7) : 32'h0400 | ((k > 9) ? 32'h0800 : 0);
      pins = k < 8 || k == 9 || k == 10;
      wrM(v);
      bus(1'b0, 1'b0, 14'h0000, 16'h0000);
      n0 = nBound;
      if (pins)
        u_src.run(3, v[8], v[7], 1);
      else
        u_lp.run(3, v[8], v[7], 1);
      repeat (20) @(negedge clk_sys);
      chk("bounds", 16'(nBound - n0), (k == 9 || k == 11) ? 16'h0000 : 16'h0003);
      chk("widthErr", 16'(timing.widthError), 16'h0000);
    end
    wrM(32'h0100);
    bus(1'b0, 1'b0, 14'h0000, 16'h0000);
    u_src.run(1, 1'b1, 1'b0, 2);
    repeat (20) @(negedge clk_sys);
    chk("widthErr", 16'(timing.widthError), 16'h0001);
    wrM(32'h0100);
    rdChk(14'h0000, 16'h0100);
    chk("widthErr", 16'(timing.widthError), 16'h0000);
    testDone();
  end
endmodule // tb_top

`default_nettype wire
